/* File: logic/fcc_defines.svh */
// opcode, length, field and timing constants of the command interpreter
`ifndef FCC_DEFINES_SVH
`define FCC_DEFINES_SVH
`define FCC_OP_CONFIG 8'h13
`define FCC_OP_SPECIFY 8'h03
`define FCC_OP_DUMP 8'h0e
`define FCC_OP_PERP 8'h12
`define FCC_OP_LOCK 8'h14
`define FCC_OP_RSEEK 8'h8f
`define FCC_OP_READ_ID 8'h0a
`define FCC_OP_FORMAT 8'h0d
`define FCC_MASK_D6 8'hbf
`define FCC_MASK_D7 8'h7f
`define FCC_XF_READ 5'h06
`define FCC_XF_READ_DEL 5'h0c
`define FCC_XF_WRITE 5'h05
`define FCC_XF_WRITE_DEL 5'h09
`define FCC_XF_READ_TRK 5'h02
`define FCC_XF_VERIFY 5'h16
// command lengths in bytes, opcode included
`define FCC_LEN_CONFIG 4'h4
`define FCC_LEN_SPECIFY 4'h3
`define FCC_LEN_PERP 4'h2
`define FCC_LEN_RSEEK 4'h3
`define FCC_LEN_READ_ID 4'h2
`define FCC_LEN_FORMAT 4'h6
`define FCC_LEN_XFER 4'h9
`define FCC_LEN_ONE 4'h1
// result lengths in bytes
`define FCC_RES_DUMP 4'ha
`define FCC_RES_STATUS 4'h7
`define FCC_RES_ONE 4'h1
// parameter byte slots (opcode excluded)
`define FCC_P_DRV 3'h0
`define FCC_P_CYL 3'h1
`define FCC_P_HEAD 3'h2
`define FCC_P_SEC 3'h3
`define FCC_P_SIZE 3'h4
`define FCC_P_EOT 3'h5
`define FCC_P_FMT_SC 3'h2
// result slots and dump byte positions
`define FCC_R_ST0 3'h0
`define FCC_R_ST1 3'h1
`define FCC_R_ST2 3'h2
`define FCC_R_CYL 3'h3
`define FCC_DB_SRT 4'h4
`define FCC_DB_HLT 4'h5
`define FCC_DB_SECT 4'h6
`define FCC_DB_LOCK 4'h7
`define FCC_DB_CFG 4'h8
// bit positions
`define FCC_DIR_BIT 6
`define FCC_LOCK_OP_BIT 7
`define FCC_EIS_BIT 6
`define FCC_FIFO_CONTROL_FLAG_BIT 5
// fixed values
`define FCC_ST0_INVALID 8'h80
`define FCC_ST0_SEEK_FAIL 8'h50
`define FCC_PERP_GAP_WG 6'h00
`define FCC_CFG_RESET 8'h00
`define FCC_CYL_MAX 8'hff
// step timing
`define FCC_CLK_PERIOD_NS 50
`define FCC_STEP_TIME_NS 3000
`define FCC_STEP_CYC ((`FCC_STEP_TIME_NS+`FCC_CLK_PERIOD_NS-1)/`FCC_CLK_PERIOD_NS)
`endif

/* File: logic/fcc_pkg.sv */
// types shared by the command interpreter modules
`default_nettype none
package fcc_pkg;
  typedef enum logic [6:0] {
    FCC_IDLE = 7'b0000001,
    FCC_PARAM = 7'b0000010,
    FCC_EXEC = 7'b0000100,
    FCC_SEEK = 7'b0001000,
    FCC_WAIT = 7'b0010000,
    FCC_RLOAD = 7'b0100000,
    FCC_RESULT = 7'b1000000
  } fcc_state_t;
  typedef enum logic [3:0] {
    FCC_CL_CFG, FCC_CL_SPEC, FCC_CL_PERP, FCC_CL_LOCK, FCC_CL_DUMP,
    FCC_CL_INV, FCC_CL_RSEEK, FCC_CL_FMT, FCC_CL_XFER, FCC_CL_RDID
  } fcc_cls_t;
  typedef struct packed {
    fcc_state_t state;
    fcc_cls_t cls;
    logic [7:0] op;
    logic [3:0] bcnt, need, ridx, rcnt, rd_ptr;
    logic [7:0][7:0] prm;
    logic res_valid, cmd_ready, busy;
    logic [3:0] drive_busy;
    logic [3:0][7:0] present_cylinder;
    logic [7:0] cfg, precomp_start_track, spec1, spec2, sc, end_sector, seek_to;
    logic last_fmt, lock, seek_go, xfer_go, id_req, id_got;
    logic [6:0][7:0] res;
  } fcc_top_st_t;
  typedef struct packed {
    logic busy, step, dir, done, fail, sync1, sync2;
    logic [7:0] cyl, to;
    logic [11:0] tmr;
  } fcc_seek_st_t;
endpackage : fcc_pkg
`default_nettype wire

/* File: logic/fcc_result_mem.sv */
// small result byte memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module fcc_result_mem #(
  parameter int W = 8,
  parameter int D = 10,
  parameter int AW = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_wr,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  logic [W-1:0] mem [D];
  // no reset: contents are always written before they are read
  always_ff @(posedge i_ref_clk) begin
    if (i_wr) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : fcc_result_mem
`default_nettype wire

/* File: logic/fcc_seek.sv */
// head stepper that walks one drive from a start to a target cylinder
`timescale 1ns/1ns
`default_nettype none
`include "fcc_defines.svh"
module fcc_seek #(
  parameter int unsigned STEP_CYC = `FCC_STEP_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [7:0] i_from,
  input wire logic [7:0] i_to,
  input wire logic i_fault_pin,
  output logic o_step,
  output logic o_dir,
  output logic o_done,
  output logic o_fail,
  output logic [7:0] o_cyl
);
  import fcc_pkg::*;
  fcc_seek_st_t s, next_s;

  ////////////////////////////////////////////////////////////////////
  // one step per step period; a drive fault ends the walk once it has passed the two sync flops
  always_comb begin
    next_s = s;
    next_s.step = 1'b0;
    next_s.done = 1'b0;
    next_s.sync1 = i_fault_pin;
    next_s.sync2 = s.sync1;
    if (!s.busy) begin
      if (i_start) begin
        next_s.busy = 1'b1;
        next_s.cyl = i_from;
        next_s.to = i_to;
        next_s.fail = 1'b0;
        next_s.tmr = '0;
      end
    end else if (s.sync2) begin
      next_s.busy = 1'b0; // cyl holds where the walk stopped
      next_s.fail = 1'b1;
      next_s.done = 1'b1;
    end else if (s.tmr != '0) begin
      next_s.tmr = s.tmr - 12'h001;
    end else if (s.cyl == s.to) begin
      next_s.busy = 1'b0;
      next_s.done = 1'b1;
    end else begin
      next_s.step = 1'b1;
      next_s.dir = s.to > s.cyl;
      next_s.cyl = (s.to > s.cyl) ? s.cyl + 8'h01 : s.cyl - 8'h01;
      next_s.tmr = 12'(STEP_CYC - 1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_step = s.step;
  assign o_dir = s.dir;
  assign o_done = s.done;
  assign o_fail = s.fail;
  assign o_cyl = s.cyl;
endmodule : fcc_seek
`default_nettype wire

/* File: logic/fcc_top.sv */
// command phase decoder and result sequencer of the floppy controller
// Functional notes
// [R1] configure: opcode, zero, flag byte, precomp track
// [R2] relative seek: direction in D6, drive, count
// [R3] register dump: ten result bytes, no execution
// [R4] dump byte eight: lock, perp, gap, gate
// [R5] sector byte: sectors if format, else end
// [R6] read id returns first good id found
// [R7] perpendicular mode recognised by its opcode
// [R8] unknown opcode: standby, one byte 80h
// [R9] lock: D7 sets lock, result bit four
// [R10] drive select bits stay internal only
// [R11] host keeps drive select consistent externally
// [R12] transfer commands share parameters and results
// [R13] implied seek runs before transfer when enabled
// [R14] drive busy shown during implied seek
// [R15] failed seek reported in status, cylinder; a failed relative seek returns to idle with no result
`timescale 1ns/1ns
`default_nettype none
`include "fcc_defines.svh"
module fcc_top (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_cmd_data,
  output logic o_cmd_ready,
  input wire logic i_res_rd,
  output logic [7:0] o_res_data,
  output logic o_res_valid,
  output logic o_busy,
  output logic [3:0] o_drive_busy,
  output logic o_xfer_start,
  output logic [4:0] o_xfer_code,
  input wire logic i_xfer_done,
  input wire logic [7:0] i_xfer_st0,
  input wire logic [7:0] i_xfer_st1,
  input wire logic [7:0] i_xfer_st2,
  output logic o_id_req,
  input wire logic i_id_valid,
  input wire logic [7:0] i_id_c,
  input wire logic [7:0] i_id_h,
  input wire logic [7:0] i_id_r,
  input wire logic [7:0] i_id_n,
  output logic o_step,
  output logic o_step_dir,
  input wire logic i_drive_fault,
  output logic o_fifo_control_flag,
  output logic [3:0] o_fifo_threshold,
  output logic [7:0] o_precomp_start_track
);
  import fcc_pkg::*;
  fcc_top_st_t s, next_s;
  logic sk_done, sk_fail;
  logic [7:0] sk_cyl, rbyte;
  logic [1:0] ds;

  ////////////////////////////////////////////////////////////////////
  // opcode decode; exact codes first, then the shared transfer codes
  function automatic fcc_cls_t cls_of(input logic [7:0] b);
    fcc_cls_t c;
    c = FCC_CL_INV; // [R8]
    if (b == `FCC_OP_CONFIG) c = FCC_CL_CFG;
    else if (b == `FCC_OP_SPECIFY) c = FCC_CL_SPEC;
    else if (b == `FCC_OP_DUMP) c = FCC_CL_DUMP;
    else if (b == `FCC_OP_PERP) c = FCC_CL_PERP; // [R7]
    else if ((b & `FCC_MASK_D7) == `FCC_OP_LOCK) c = FCC_CL_LOCK; // [R9]
    else if ((b & `FCC_MASK_D6) == `FCC_OP_RSEEK) c = FCC_CL_RSEEK; // [R2]
    else if ((b & `FCC_MASK_D6) == `FCC_OP_READ_ID) c = FCC_CL_RDID;
    else if ((b & `FCC_MASK_D6) == `FCC_OP_FORMAT) c = FCC_CL_FMT;
    // only bits 4:0 tell the transfer commands apart
    else if (b[4:0] inside {`FCC_XF_READ, `FCC_XF_READ_DEL,
        `FCC_XF_WRITE, `FCC_XF_WRITE_DEL, `FCC_XF_READ_TRK,
        `FCC_XF_VERIFY}) c = FCC_CL_XFER; // [R12]
    return c;
  endfunction : cls_of

  function automatic logic [3:0] need_of(input fcc_cls_t c);
    logic [3:0] n;
    n = `FCC_LEN_ONE;
    unique case (c)
      FCC_CL_CFG: n = `FCC_LEN_CONFIG; // [R1]
      FCC_CL_SPEC: n = `FCC_LEN_SPECIFY;
      FCC_CL_PERP: n = `FCC_LEN_PERP;
      FCC_CL_RSEEK: n = `FCC_LEN_RSEEK; // [R2]
      FCC_CL_RDID: n = `FCC_LEN_READ_ID;
      FCC_CL_FMT: n = `FCC_LEN_FORMAT;
      FCC_CL_XFER: n = `FCC_LEN_XFER; // [R12]
      default: n = `FCC_LEN_ONE;
    endcase
    return n;
  endfunction : need_of

  ////////////////////////////////////////////////////////////////////
  // result byte for the slot being loaded
  always_comb begin
    rbyte = s.res[s.ridx[2:0]];
    if (s.cls == FCC_CL_INV) begin
      rbyte = `FCC_ST0_INVALID; // [R8]
    end else if (s.cls == FCC_CL_LOCK) begin
      rbyte = {3'h0, s.lock, 4'h0}; // [R9]
    end else if (s.cls == FCC_CL_DUMP) begin
      // [R3]
      unique case (s.ridx)
        `FCC_DB_SRT: rbyte = s.spec1;
        `FCC_DB_HLT: rbyte = s.spec2;
        `FCC_DB_SECT: rbyte = s.last_fmt ? s.sc : s.end_sector; // [R5]
        `FCC_DB_LOCK: rbyte = {s.lock, 1'b0, `FCC_PERP_GAP_WG}; // [R4]
        `FCC_DB_CFG: rbyte = {1'b0, s.cfg[6:0]}; // [R4]
        default: begin
          if (s.ridx < `FCC_DB_SRT) rbyte = s.present_cylinder[s.ridx[1:0]];
          else rbyte = s.precomp_start_track;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // main sequencer: command bytes in, execute, load and hand results
  always_comb begin
    next_s = s;
    ds = s.prm[`FCC_P_DRV][1:0]; // [R10] internal use only
    next_s.seek_go = 1'b0;
    next_s.xfer_go = 1'b0;
    next_s.id_req = 1'b0;
    unique case (s.state)
      FCC_IDLE: begin
        if (i_cmd_wr) begin
          next_s.op = i_cmd_data;
          next_s.cls = cls_of(i_cmd_data);
          next_s.need = need_of(next_s.cls);
          next_s.bcnt = 4'h1;
          next_s.state = (next_s.need == `FCC_LEN_ONE) ? FCC_EXEC
                                                       : FCC_PARAM;
        end
      end
      FCC_PARAM: begin
        if (i_cmd_wr) begin
          next_s.prm[3'(s.bcnt - 4'h1)] = i_cmd_data;
          next_s.bcnt = s.bcnt + 4'h1;
          if (next_s.bcnt == s.need) next_s.state = FCC_EXEC;
        end
      end
      FCC_EXEC: begin
        next_s.ridx = '0;
        next_s.state = FCC_IDLE;
        unique case (s.cls)
          FCC_CL_CFG: begin
            next_s.cfg = s.prm[1]; // [R1]
            next_s.precomp_start_track = s.prm[2]; // [R1]
          end
          FCC_CL_SPEC: begin
            next_s.spec1 = s.prm[0];
            next_s.spec2 = s.prm[1];
          end
          FCC_CL_PERP: next_s.state = FCC_IDLE; // fields not modelled
          FCC_CL_LOCK: begin
            next_s.lock = s.op[`FCC_LOCK_OP_BIT]; // [R9]
            next_s.rcnt = `FCC_RES_ONE;
            next_s.state = FCC_RLOAD;
          end
          FCC_CL_DUMP: begin
            next_s.rcnt = `FCC_RES_DUMP; // [R3]
            next_s.state = FCC_RLOAD;
          end
          FCC_CL_INV: begin
            next_s.rcnt = `FCC_RES_ONE; // [R8]
            next_s.state = FCC_RLOAD;
          end
          FCC_CL_RSEEK: begin
            // saturate at the ends rather than wrap the cylinder
            if (s.op[`FCC_DIR_BIT]) begin // [R2]
              next_s.seek_to = (s.present_cylinder[ds] > `FCC_CYL_MAX - s.prm[1])
                ? `FCC_CYL_MAX : s.present_cylinder[ds] + s.prm[1];
            end else begin
              next_s.seek_to = (s.present_cylinder[ds] < s.prm[1])
                ? 8'h00 : s.present_cylinder[ds] - s.prm[1];
            end
            next_s.seek_go = 1'b1;
            next_s.drive_busy[ds] = 1'b1;
            next_s.state = FCC_SEEK;
          end
          FCC_CL_FMT: begin
            next_s.sc = s.prm[`FCC_P_FMT_SC];
            next_s.last_fmt = 1'b1; // [R5]
            next_s.xfer_go = 1'b1;
            next_s.state = FCC_WAIT;
          end
          FCC_CL_XFER: begin
            next_s.end_sector = s.prm[`FCC_P_EOT];
            next_s.last_fmt = 1'b0; // [R5]
            if (s.cfg[`FCC_EIS_BIT] &&
                s.prm[`FCC_P_CYL] != s.present_cylinder[ds]) begin // [R13]
              next_s.seek_to = s.prm[`FCC_P_CYL];
              next_s.seek_go = 1'b1;
              next_s.drive_busy[ds] = 1'b1; // [R14]
              next_s.state = FCC_SEEK;
            end else begin
              next_s.xfer_go = 1'b1;
              next_s.state = FCC_WAIT;
            end
          end
          FCC_CL_RDID: begin
            next_s.id_req = 1'b1; // [R6]
            next_s.id_got = 1'b0;
            next_s.state = FCC_WAIT;
          end
        endcase
      end
      FCC_SEEK: begin
        if (sk_done) begin
          next_s.present_cylinder[ds] = sk_cyl;
          next_s.drive_busy[ds] = 1'b0; // [R14]
          if (s.cls == FCC_CL_RSEEK) begin
            next_s.state = FCC_IDLE;
          end else if (sk_fail) begin
            // failure uses the ordinary transfer result layout
            next_s.res[`FCC_R_ST0] = `FCC_ST0_SEEK_FAIL |
                                     {5'h00, s.prm[`FCC_P_DRV][2:0]};
            next_s.res[`FCC_R_ST1] = 8'h00;
            next_s.res[`FCC_R_ST2] = 8'h00;
            next_s.res[`FCC_R_CYL] = sk_cyl; // [R15]
            next_s.res[4] = s.prm[`FCC_P_HEAD];
            next_s.res[5] = s.prm[`FCC_P_SEC];
            next_s.res[6] = s.prm[`FCC_P_SIZE];
            next_s.rcnt = `FCC_RES_STATUS; // [R15]
            next_s.state = FCC_RLOAD;
          end else begin
            next_s.xfer_go = 1'b1; // [R13]
            next_s.state = FCC_WAIT;
          end
        end
      end
      FCC_WAIT: begin
        // only the first good id of the cylinder is kept
        if (s.cls == FCC_CL_RDID && i_id_valid && !s.id_got) begin
          next_s.id_got = 1'b1; // [R6]
          next_s.res[3] = i_id_c;
          next_s.res[4] = i_id_h;
          next_s.res[5] = i_id_r;
          next_s.res[6] = i_id_n;
        end
        if (i_xfer_done) begin
          next_s.res[`FCC_R_ST0] = i_xfer_st0;
          next_s.res[`FCC_R_ST1] = i_xfer_st1;
          next_s.res[`FCC_R_ST2] = i_xfer_st2;
          if (s.cls != FCC_CL_RDID) begin
            next_s.res[3] = s.prm[`FCC_P_CYL]; // [R12]
            next_s.res[4] = s.prm[`FCC_P_HEAD];
            next_s.res[5] = s.prm[`FCC_P_SEC];
            next_s.res[6] = s.prm[`FCC_P_SIZE];
          end
          next_s.rcnt = `FCC_RES_STATUS;
          next_s.state = FCC_RLOAD;
        end
      end
      FCC_RLOAD: begin
        next_s.ridx = s.ridx + 4'h1;
        if (s.ridx == s.rcnt - 4'h1) begin
          next_s.rd_ptr = '0;
          next_s.res_valid = 1'b0;
          next_s.state = FCC_RESULT;
        end
      end
      FCC_RESULT: begin
        // valid drops for a cycle while the memory fetches the next
        if (s.res_valid && i_res_rd) begin
          next_s.res_valid = 1'b0;
          if (s.rd_ptr == s.rcnt - 4'h1) next_s.state = FCC_IDLE;
          else next_s.rd_ptr = s.rd_ptr + 4'h1;
        end else begin
          next_s.res_valid = 1'b1;
        end
      end
    endcase
    next_s.cmd_ready = next_s.state == FCC_IDLE ||
                       next_s.state == FCC_PARAM;
    next_s.busy = next_s.state != FCC_IDLE;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s <= '0;
      s.state <= FCC_IDLE;
      s.cls <= FCC_CL_INV;
      s.cfg <= `FCC_CFG_RESET;
      s.cmd_ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // result store and head stepper
  fcc_result_mem #(.W(8), .D(10), .AW(4)) u_mem (
    .i_ref_clk(i_ref_clk),
    .i_wr(s.state == FCC_RLOAD),
    .i_waddr(s.ridx),
    .i_wdata(rbyte),
    .i_raddr(s.rd_ptr),
    .o_rdata(o_res_data)
  );

  fcc_seek u_seek (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(s.seek_go),
    .i_from(s.present_cylinder[ds]),
    .i_to(s.seek_to),
    .i_fault_pin(i_drive_fault),
    .o_step(o_step),
    .o_dir(o_step_dir),
    .o_done(sk_done),
    .o_fail(sk_fail),
    .o_cyl(sk_cyl)
  );

  // outputs straight from state flops
  assign o_cmd_ready = s.cmd_ready;
  assign o_res_valid = s.res_valid;
  assign o_busy = s.busy;
  assign o_drive_busy = s.drive_busy;
  assign o_xfer_start = s.xfer_go;
  assign o_xfer_code = s.op[4:0];
  assign o_id_req = s.id_req;
  assign o_fifo_control_flag = s.cfg[`FCC_FIFO_CONTROL_FLAG_BIT];
  assign o_fifo_threshold = s.cfg[3:0];
  assign o_precomp_start_track = s.precomp_start_track;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_one_byte_cmd(logic [7:0] code);
    s.state == FCC_IDLE && i_cmd_wr && i_cmd_data == code;
  endsequence
  sequence s_first_result;
    ##4 o_res_valid;
  endsequence
  // ten load cycles pass before the first dump byte stands
  sequence s_first_dump;
    ##13 o_res_valid;
  endsequence

  property p_invalid;
    s.state == FCC_IDLE && i_cmd_wr && cls_of(i_cmd_data) == FCC_CL_INV
      |-> s_first_result ##0 o_res_data == `FCC_ST0_INVALID;
  endproperty
  a_invalid: assert property (p_invalid) // [R8]
    else $error("invalid opcode result wrong");

  property p_lock;
    logic v;
    (s.state == FCC_IDLE && i_cmd_wr &&
     (i_cmd_data & `FCC_MASK_D7) == `FCC_OP_LOCK, v = i_cmd_data[7])
      |-> s_first_result ##0 o_res_data == {3'h0, v, 4'h0};
  endproperty
  a_lock: assert property (p_lock) // [R9]
    else $error("lock result wrong");

  property p_dump_first;
    s_one_byte_cmd(`FCC_OP_DUMP) |-> s_first_dump ##0
      (o_res_data == s.present_cylinder[0] && s.rcnt == `FCC_RES_DUMP);
  endproperty
  a_dump_first: assert property (p_dump_first) // [R3]
    else $error("dump result start wrong");

  property p_dump_lock_byte;
    s.state == FCC_RESULT && s.cls == FCC_CL_DUMP && o_res_valid &&
      s.rd_ptr == `FCC_DB_LOCK |-> o_res_data[7] == s.lock &&
      o_res_data[6] == 1'b0;
  endproperty
  a_dump_lock_byte: assert property (p_dump_lock_byte) // [R4]
    else $error("dump lock byte wrong");

  property p_dump_sector;
    s.state == FCC_RESULT && s.cls == FCC_CL_DUMP && o_res_valid &&
      s.rd_ptr == `FCC_DB_SECT |->
      o_res_data == (s.last_fmt ? s.sc : s.end_sector);
  endproperty
  a_dump_sector: assert property (p_dump_sector) // [R5]
    else $error("dump sector byte wrong");

  property p_read_id;
    s.state == FCC_WAIT && s.cls == FCC_CL_RDID && i_id_valid &&
      !s.id_got |=> s.id_got && s.res[3] == $past(i_id_c);
  endproperty
  a_read_id: assert property (p_read_id) // [R6]
    else $error("first id not captured");

  property p_xfer_len;
    s.state == FCC_IDLE && i_cmd_wr &&
      cls_of(i_cmd_data) == FCC_CL_XFER |=> s.need == `FCC_LEN_XFER;
  endproperty
  a_xfer_len: assert property (p_xfer_len) // [R12]
    else $error("transfer length wrong");

  property p_implied_seek;
    s.state == FCC_EXEC && s.cls == FCC_CL_XFER &&
      s.cfg[`FCC_EIS_BIT] && s.prm[`FCC_P_CYL] != s.present_cylinder[ds]
      |=> s.state == FCC_SEEK && s.seek_go && !o_xfer_start;
  endproperty
  a_implied_seek: assert property (p_implied_seek) // [R13]
    else $error("implied seek not started");

  property p_seek_busy;
    s.state == FCC_SEEK && !$past(sk_done) |-> o_drive_busy[ds];
  endproperty
  a_seek_busy: assert property (p_seek_busy) // [R14]
    else $error("drive busy missing in seek");

  property p_seek_fail;
    s.state == FCC_SEEK && s.cls == FCC_CL_XFER && sk_done && sk_fail
      |=> s.state == FCC_RLOAD && s.res[3] == $past(sk_cyl) &&
      s.res[0][7:4] == `FCC_ST0_SEEK_FAIL >> 4;
  endproperty
  a_seek_fail: assert property (p_seek_fail) // [R15]
    else $error("seek failure not reported");

  property p_config;
    s.state == FCC_EXEC && s.cls == FCC_CL_CFG
      |=> s.cfg == $past(s.prm[1]) && s.precomp_start_track == $past(s.prm[2]);
  endproperty
  a_config: assert property (p_config) // [R1]
    else $error("configure not stored");
endmodule : fcc_top
`default_nettype wire

/* File: testbench/fcc_exec_model.sv */
// execution and drive side stand-in: answers transfer and read id starts
`timescale 1ns/1ns
`default_nettype none
module fcc_exec_model (
  input wire logic i_ref_clk,
  input wire logic i_start,
  input wire logic i_id_req,
  output logic o_done,
  output logic o_id_valid,
  output logic [7:0] o_st0,
  output logic [31:0] o_chrn
);
  initial begin
    o_done = 1'b0;
    o_id_valid = 1'b0;
    o_st0 = 8'hfe;
    o_chrn = 32'hf8fefcfd;
  end
  // two ids in a row, the second must be ignored; lines garbled outside
  always begin
    @(negedge i_ref_clk);
    if (i_start || i_id_req) begin
      repeat (4) @(posedge i_ref_clk);
      o_id_valid <= 1'b1;
      o_chrn <= 32'h07010302;
      @(posedge i_ref_clk);
      o_chrn <= 32'h08000404;
      @(posedge i_ref_clk);
      o_id_valid <= 1'b0;
      o_done <= 1'b1;
      o_st0 <= 8'h01;
      @(posedge i_ref_clk);
      o_done <= 1'b0;
      o_st0 <= 8'hfe;
      o_chrn <= 32'hf8fefcfd;
    end
  end
endmodule : fcc_exec_model
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the floppy command interpreter
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, done, idv, fault = 0;
  logic rdy, rv, busy, xs, idr, stp, sdir;
  logic [7:0] din = 8'h00, rdat, st0, pre;
  logic [31:0] chrn;
  logic [3:0] db, dbs, thr;
  logic [4:0] xcode;
  logic fcf;
  int errors = 0, n_tests = 0, nst = 0;
  always #25 clk = ~clk;
  fcc_top fcc_top_i (.i_ref_clk(clk), .i_sys_rst(rst), .i_cmd_wr(wr),
    .i_cmd_data(din), .o_cmd_ready(rdy), .i_res_rd(rd), .o_res_data(rdat),
    .o_res_valid(rv), .o_busy(busy), .o_drive_busy(db), .o_xfer_start(xs),
    .o_xfer_code(xcode), .i_xfer_done(done), .i_xfer_st0(st0),
    .i_xfer_st1(8'h00), .i_xfer_st2(8'h00), .o_id_req(idr),
    .i_id_valid(idv), .i_id_c(chrn[31:24]), .i_id_h(chrn[23:16]),
    .i_id_r(chrn[15:8]), .i_id_n(chrn[7:0]), .o_step(stp),
    .o_step_dir(sdir),
    .i_drive_fault(fault), .o_fifo_control_flag(fcf),
    .o_fifo_threshold(thr), .o_precomp_start_track(pre));
  fcc_exec_model fcc_exec_model_i (.i_ref_clk(clk), .i_start(xs),
    .i_id_req(idr), .o_done(done), .o_id_valid(idv), .o_st0(st0),
    .o_chrn(chrn));
  ////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // bounded wait on a settled level; drive busy and steps gathered meanwhile
  task wait_for(input bit want_rv);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(negedge clk);
      dbs = dbs | db;
      if (stp === 1'b1) nst++;
      if (want_rv ? (rv === 1'b1) : (busy === 1'b0 && rdy === 1'b1)) break;
    end
    if (k == 3000) begin
      errors++;
      $display("BAD %0t wait ran out", $time);
      wrap_up();
    end
  endtask : wait_for
  // one-cycle write strobes with a gap edge between bytes
  task send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(posedge clk);
      wr <= 1'b1;
      din <= q[i];
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask : send
  // check each byte at a falling edge, pop it at the second rising edge after
  task take(input logic [7:0] q[$], input string name);
    foreach (q[i]) begin
      wait_for(1'b1);
      chk(rdat, q[i]);
      @(posedge clk);
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
    end
    wait_for(1'b0);
    $display("test %s done", name);
  endtask : take
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    send('{8'h94});
    take('{8'h10}, "lock");
    send('{8'h13, 8'h00, 8'h45, 8'h22});
    take('{}, "configure");
    chk({4'h0, thr}, 8'h05);
    chk(pre, 8'h22);
    chk({7'h0, fcf}, 8'h00);
    send('{8'h12, 8'h00});
    take('{}, "perpendicular");
    chk({7'h0, rv}, 8'h00);
    send('{8'h1f});
    take('{8'h80}, "invalid");
    send('{8'h03, 8'ha1, 8'h05});
    dbs = 4'h0;
    nst = 0;
    send('{8'hcf, 8'h01, 8'h03});
    take('{}, "relative seek");
    chk({4'h0, dbs}, 8'h02);
    chk(8'(nst), 8'h03);
    chk({7'h0, sdir}, 8'h01);
    send('{8'h4a, 8'h00});
    take('{8'h01, 8'h00, 8'h00, 8'h07, 8'h01, 8'h03, 8'h02},
      "read id");
    dbs = 4'h0;
    nst = 0;
    send('{8'h06, 8'h00, 8'h02, 8'h00, 8'h01, 8'h02, 8'h09, 8'h1b, 8'hff});
    take('{8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h01, 8'h02}, "xfer");
    chk({4'h0, dbs}, 8'h01);
    chk(8'(nst), 8'h02);
    chk({3'h0, xcode}, 8'h06);
    // a faulted drive ends the implied seek before its first step
    dbs = 4'h0;
    @(posedge clk);
    fault <= 1'b1;
    send('{8'h06, 8'h02, 8'h05, 8'h00, 8'h01, 8'h02, 8'h09, 8'h1b, 8'hff});
    take('{8'h52, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02},
      "seek fail");
    chk({4'h0, dbs}, 8'h04);
    @(posedge clk);
    fault <= 1'b0;
    send('{8'h0e});
    take('{8'h02, 8'h03, 8'h00, 8'h00, 8'ha1, 8'h05, 8'h09, 8'h80, 8'h45,
      8'h22}, "dump");
    send('{8'h0d, 8'h00, 8'h02, 8'h12, 8'h1b, 8'he5});
    take('{8'h01, 8'h00, 8'h00, 8'h02, 8'h12, 8'h1b, 8'he5},
      "format");
    send('{8'h0e});
    take('{8'h02, 8'h03, 8'h00, 8'h00, 8'ha1, 8'h05, 8'h12, 8'h80, 8'h45,
      8'h22}, "dump after format");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
